// ===== rtl/spibr_pkg.sv
// constants, register map and state type of the buffered spi master
package spibr_pkg;
    // register indices; byte address on the bus is index * 4
    localparam logic [13:0] IDX_ENABLE = 14'h14a0;
    localparam logic [13:0] IDX_CTRL = 14'h14a1;
    localparam logic [13:0] IDX_DLEN = 14'h14a2;
    localparam logic [13:0] IDX_MID = 14'h14a3;
    localparam logic [13:0] IDX_CMD0 = 14'h14a4;
    localparam logic [13:0] IDX_FMT = 14'h14ab;
    localparam logic [13:0] IDX_PORT = 14'h14ac;
    localparam logic [13:0] IDX_COUNT = 14'h14ad;
    localparam logic [13:0] IDX_WPTR = 14'h14ae;
    localparam logic [13:0] IDX_RPTR = 14'h14af;
    localparam logic [13:0] IDX_STATUS = 14'h14b8;
    // spi_block_enable fields
    localparam int EN_BIT = 7;
    localparam int BIDIR_BIT = 6;
    localparam int DIV_MSB = 3;
    // transfer_control fields
    localparam int CTRL_BYPASS = 5;
    localparam int CTRL_DATAEN = 4;
    localparam int CTRL_RD = 3;
    localparam int CTRL_LEN_MSB = 2;
    // signal_format_control fields
    localparam int FMT_CSADD = 4;
    localparam int FMT_CSMORE = 3;
    localparam int FMT_CKMORE = 2;
    localparam int FMT_CPOL = 1;
    localparam int FMT_CPHA = 0;
    // status fields
    localparam int ST_FIN = 0;
    localparam int ST_MID = 1;
    localparam int MID_MSB = 7;
    localparam int MID_LSB = 4;
    localparam logic [2:0] MAX_CMD = 3'h5;
    localparam logic [7:0] RX_BASE = 8'h80;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] IDLE_TX = 8'hff;
    localparam logic [8:0] FULL_LEN = 9'h100;
    localparam logic [1:0] SETUP_BASE = 2'h1;
    localparam logic [1:0] SETUP_EXTRA = 2'h2;
    localparam logic [2:0] TAIL_BASE = 3'h1;
    localparam logic [2:0] TAIL_EXTRA = 3'h3;
    localparam logic [2:0] TAIL_CLOCKS = 3'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} spibr_state_t;
endpackage

// ===== rtl/spibr_sync.sv
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module spibr_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/spibr_ram.sv
// byte buffer with one write port and two asynchronous read ports
`timescale 1ns/1ps
`default_nettype none
module spibr_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddrA,
    output logic [WIDTH-1:0] rdDataA,
    input wire logic [AW-1:0] rdAddrB,
    output logic [WIDTH-1:0] rdDataB
);
    logic [WIDTH-1:0] mem [DEPTH];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[wrAddr] <= wrData;
        end
    end
    assign rdDataA = mem[rdAddrA];
    assign rdDataB = mem[rdAddrB];
endmodule
`default_nettype wire

// ===== rtl/spibr_top.sv
// four-wire spi master with 256-byte buffer behind a wishbone slave
// How it works
// R1 - three states idle, command, data; idle at reset
// R2 - when enabled, control write starts a transfer
// R3 - skip flag jumps straight to data state
// R4 - otherwise send command bytes in command state
// R5 - after commands: data if enabled, else idle
// R6 - unidirectional data: write out or read in
// R7 - bidirectional ignores direction, shifts both ways
// R8 - all data bytes done returns to idle
// R9 - every byte goes most significant bit first
// R10 - zero to five transmit-only command bytes
// R11 - eight-bit data length, up to 256 bytes
// R12 - five format bits shape select and clock
// R13 - 256-byte buffer, halves split when bidirectional
// R14 - receive bytes start at 0x80 when bidirectional
// R15 - data port uses and bumps hardware pointers
// R16 - both pointers readable by software
// R17 - load a pointer, then access any byte
// R18 - finish flag when count equals data length
// R19 - middle flag at sixteen times midpoint count
// R20 - programmable serial clock, at most half system clock
// R21 - master on clock, select, data in, out
// R22 - status bits set by events, write-one clears
// R23 - byte count clears at start, counts bytes
// R24 - select low around bits, sampling per mode
`timescale 1ns/1ps
`default_nettype none
module spibr_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [7:0] dat_i,
    input wire logic sel_i,
    output logic [7:0] dat_o,
    output logic ack_o,
    output logic spiClk,
    output logic spiCsN,
    output logic spiDout,
    input wire logic spiDin
);
    spibr_pkg::spibr_state_t stateQ;
    logic [7:0] enQ, ctrlQ, dlenQ, midQ, fmtQ, wrPtrQ, rdPtrQ, datQ, rdMux;
    logic [7:0] cmdQ [5];
    logic ackQ, finQ, midStQ, goQ;
    logic [3:0] divCntQ;
    logic [1:0] setupQ;
    logic [2:0] tailQ, bitQ, cmdIdxQ, cmdLen, tailBase;
    logic halfQ, sclkQ, csnQ, sdoQ, sdiS;
    logic [8:0] cntQ, lenFull;
    logic [7:0] txIdxQ, rxIdxQ, shQ, rxQ, rxByte, ramA, ramB, txData;
    logic [7:0] engAddr, nextByte, ramWrAddr, ramWrData;
    logic busReq, wrAcc, rdAcc, tick, byteEnd, cmdLast, dataLast, more;
    logic bidir, rxOnly, cpol, cpha, engWe, busWe, finSet, midSet;
    spibr_pkg::spibr_state_t nextState;

    assign busReq = cyc_i & stb_i;
    // a write lands and a read has its side effect on the acknowledge edge
    assign wrAcc = busReq & ackQ & we_i & sel_i & ce;
    assign rdAcc = busReq & ackQ & ~we_i & ce;
    assign bidir = enQ[spibr_pkg::BIDIR_BIT];
    assign rxOnly = ctrlQ[spibr_pkg::CTRL_RD] & ~bidir; // see R6 see R7
    assign cpol = fmtQ[spibr_pkg::FMT_CPOL];
    assign cpha = fmtQ[spibr_pkg::FMT_CPHA];
    // lengths above five clamp to five
    assign cmdLen = (ctrlQ[spibr_pkg::CTRL_LEN_MSB:0] > spibr_pkg::MAX_CMD)
        ? spibr_pkg::MAX_CMD : ctrlQ[spibr_pkg::CTRL_LEN_MSB:0]; // see R10
    // a length of zero means a full 256-byte field
    assign lenFull = (dlenQ == 8'h00) ? spibr_pkg::FULL_LEN
        : {1'b0, dlenQ}; // see R11
    assign tailBase = fmtQ[spibr_pkg::FMT_CSMORE] ? spibr_pkg::TAIL_EXTRA
        : spibr_pkg::TAIL_BASE; // see R12
    // half serial period is divider+1 system clocks, fastest clk/2
    assign tick = (divCntQ == enQ[spibr_pkg::DIV_MSB:0]); // see R20
    assign byteEnd = ce & ~goQ & (stateQ != spibr_pkg::ST_IDLE) & tick
        & (setupQ == 2'h0) & (tailQ == 3'h0) & halfQ & (bitQ == 3'h7);
    assign rxByte = cpha ? {rxQ[6:0], sdiS} : rxQ;
    assign cmdLast = (cmdIdxQ == cmdLen - 3'h1);
    assign dataLast = ((cntQ + 9'h001) == lenFull);
    assign engAddr = (stateQ == spibr_pkg::ST_DATA)
        ? txIdxQ + 8'h01 : 8'h00;
    assign txData = rxOnly ? spibr_pkg::IDLE_TX : ramB; // see R6

    // decides what follows the byte that is ending
    always_comb begin
        more = 1'b0;
        nextByte = txData;
        nextState = stateQ;
        if (stateQ == spibr_pkg::ST_CMD) begin
            if (!cmdLast) begin
                more = 1'b1;
                nextByte = cmdQ[cmdIdxQ + 3'h1];
            end else if (ctrlQ[spibr_pkg::CTRL_DATAEN]) begin
                more = 1'b1;
                nextState = spibr_pkg::ST_DATA; // see R5
            end
        end else if (stateQ == spibr_pkg::ST_DATA) begin
            more = ~dataLast; // see R8
        end
    end

    assign engWe = byteEnd & (stateQ == spibr_pkg::ST_DATA)
        & (rxOnly | bidir); // see R6 see R7
    assign busWe = wrAcc & (adr_i[15:2] == spibr_pkg::IDX_PORT) & ~engWe;
    // engine write wins the shared port; a colliding bus byte is lost
    assign ramWrAddr = engWe ? rxIdxQ : wrPtrQ;
    assign ramWrData = engWe ? rxByte : dat_i;

    spibr_ram #(.WIDTH(8), .DEPTH(256), .AW(8)) u_ram ( // see R13
        .clk(clk),
        .we(engWe | busWe),
        .wrAddr(ramWrAddr),
        .wrData(ramWrData),
        .rdAddrA(rdPtrQ),
        .rdDataA(ramA),
        .rdAddrB(engAddr),
        .rdDataB(ramB)
    );

    spibr_sync u_sdi (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .din(spiDin),
        .dout(sdiS)
    );

    // read data mux
    always_comb begin
        rdMux = spibr_pkg::RESET_VAL;
        case (adr_i[15:2])
            spibr_pkg::IDX_ENABLE: rdMux = enQ;
            spibr_pkg::IDX_CTRL: rdMux = ctrlQ;
            spibr_pkg::IDX_DLEN: rdMux = dlenQ;
            spibr_pkg::IDX_MID: rdMux = midQ;
            spibr_pkg::IDX_FMT: rdMux = fmtQ;
            spibr_pkg::IDX_PORT: rdMux = ramA; // see R15
            spibr_pkg::IDX_COUNT: rdMux = cntQ[7:0];
            spibr_pkg::IDX_WPTR: rdMux = wrPtrQ; // see R16
            spibr_pkg::IDX_RPTR: rdMux = rdPtrQ; // see R16
            spibr_pkg::IDX_STATUS: rdMux = {6'h00, midStQ, finQ};
            default: begin
                if (adr_i[15:2] >= spibr_pkg::IDX_CMD0
                        && adr_i[15:2] < spibr_pkg::IDX_CMD0 + 14'h0005) begin
                    rdMux = cmdQ[3'(adr_i[15:2] - spibr_pkg::IDX_CMD0)];
                end
            end
        endcase
    end

    // wishbone answer: ack one cycle after the request, dropped next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ackQ <= 1'b0;
            datQ <= spibr_pkg::RESET_VAL;
        end else if (ce) begin
            ackQ <= busReq & ~ackQ;
            if (busReq && !ackQ) begin
                datQ <= rdMux;
            end
        end
    end
    assign ack_o = ackQ;
    assign dat_o = datQ;

    // configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            enQ <= spibr_pkg::RESET_VAL;
            ctrlQ <= spibr_pkg::RESET_VAL;
            dlenQ <= spibr_pkg::RESET_VAL;
            midQ <= spibr_pkg::RESET_VAL;
            fmtQ <= spibr_pkg::RESET_VAL;
            for (int i = 0; i < 5; i++) begin
                cmdQ[i] <= spibr_pkg::RESET_VAL;
            end
        end else if (wrAcc) begin
            case (adr_i[15:2])
                spibr_pkg::IDX_ENABLE: enQ <= dat_i;
                spibr_pkg::IDX_CTRL: ctrlQ <= dat_i;
                spibr_pkg::IDX_DLEN: dlenQ <= dat_i;
                spibr_pkg::IDX_MID: midQ <= dat_i;
                spibr_pkg::IDX_FMT: fmtQ <= dat_i;
                default: begin
                    if (adr_i[15:2] >= spibr_pkg::IDX_CMD0
                            && adr_i[15:2] < spibr_pkg::IDX_CMD0 + 14'h0005) begin
                        cmdQ[3'(adr_i[15:2] - spibr_pkg::IDX_CMD0)] <= dat_i;
                    end
                end
            endcase
        end
    end

    // software buffer pointers: loadable, bumped by data port access
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtrQ <= spibr_pkg::RESET_VAL;
            rdPtrQ <= spibr_pkg::RESET_VAL;
        end else begin
            if (wrAcc && adr_i[15:2] == spibr_pkg::IDX_WPTR) begin
                wrPtrQ <= dat_i; // see R17
            end else if (wrAcc && adr_i[15:2] == spibr_pkg::IDX_PORT) begin
                wrPtrQ <= wrPtrQ + 8'h01; // see R15
            end
            if (wrAcc && adr_i[15:2] == spibr_pkg::IDX_RPTR) begin
                rdPtrQ <= dat_i; // see R17
            end else if (rdAcc && adr_i[15:2] == spibr_pkg::IDX_PORT) begin
                rdPtrQ <= rdPtrQ + 8'h01; // see R15
            end
        end
    end

    // transfer start request, acted on one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            goQ <= 1'b0;
        end else if (ce) begin
            goQ <= wrAcc & (adr_i[15:2] == spibr_pkg::IDX_CTRL)
                & enQ[spibr_pkg::EN_BIT] & (stateQ == spibr_pkg::ST_IDLE)
                & ~goQ; // see R2
        end
    end

    assign finSet = byteEnd & (stateQ == spibr_pkg::ST_DATA) & dataLast;
    assign midSet = byteEnd & (stateQ == spibr_pkg::ST_DATA)
        & (midQ[spibr_pkg::MID_MSB:spibr_pkg::MID_LSB] != 4'h0)
        & ((cntQ + 9'h001)
        == {1'b0, midQ[spibr_pkg::MID_MSB:spibr_pkg::MID_LSB], 4'h0});

    // sticky event flags, write one to clear, a new event wins
    always_ff @(posedge clk) begin
        if (rst) begin
            finQ <= 1'b0;
            midStQ <= 1'b0;
        end else begin
            if (finSet) begin
                finQ <= 1'b1; // see R18 see R22
            end else if (wrAcc && adr_i[15:2] == spibr_pkg::IDX_STATUS
                    && dat_i[spibr_pkg::ST_FIN]) begin
                finQ <= 1'b0; // see R22
            end
            if (midSet) begin
                midStQ <= 1'b1; // see R19 see R22
            end else if (wrAcc && adr_i[15:2] == spibr_pkg::IDX_STATUS
                    && dat_i[spibr_pkg::ST_MID]) begin
                midStQ <= 1'b0; // see R22
            end
        end
    end

    // serial engine
    always_ff @(posedge clk) begin
        if (rst) begin
            stateQ <= spibr_pkg::ST_IDLE; // see R1
            divCntQ <= 4'h0;
            setupQ <= 2'h0;
            tailQ <= 3'h0;
            halfQ <= 1'b0;
            bitQ <= 3'h0;
            cmdIdxQ <= 3'h0;
            cntQ <= 9'h000;
            txIdxQ <= 8'h00;
            rxIdxQ <= 8'h00;
            shQ <= 8'h00;
            rxQ <= 8'h00;
            sclkQ <= 1'b0;
            csnQ <= 1'b1;
            sdoQ <= 1'b0;
        end else if (ce) begin
            if (goQ) begin
                divCntQ <= 4'h0;
                setupQ <= fmtQ[spibr_pkg::FMT_CSADD] ? spibr_pkg::SETUP_EXTRA
                    : spibr_pkg::SETUP_BASE; // see R12
                halfQ <= 1'b0;
                bitQ <= 3'h0;
                cmdIdxQ <= 3'h0;
                cntQ <= 9'h000; // see R23
                txIdxQ <= 8'h00;
                rxIdxQ <= bidir ? spibr_pkg::RX_BASE : 8'h00; // see R14
                if (ctrlQ[spibr_pkg::CTRL_BYPASS]) begin
                    stateQ <= spibr_pkg::ST_DATA; // see R3
                    shQ <= txData;
                    sdoQ <= txData[7];
                    csnQ <= 1'b0; // see R24
                end else if (cmdLen != 3'h0) begin
                    stateQ <= spibr_pkg::ST_CMD; // see R4
                    shQ <= cmdQ[0];
                    sdoQ <= cmdQ[0][7];
                    csnQ <= 1'b0; // see R24
                end else if (ctrlQ[spibr_pkg::CTRL_DATAEN]) begin
                    stateQ <= spibr_pkg::ST_DATA;
                    shQ <= txData;
                    sdoQ <= txData[7];
                    csnQ <= 1'b0;
                end
            end else if (stateQ == spibr_pkg::ST_IDLE) begin
                sclkQ <= cpol;
                csnQ <= 1'b1;
            end else if (!tick) begin
                divCntQ <= divCntQ + 4'h1;
            end else begin
                divCntQ <= 4'h0;
                if (setupQ != 2'h0) begin
                    setupQ <= setupQ - 2'h1;
                end else if (tailQ != 3'h0) begin
                    tailQ <= tailQ - 3'h1;
                    if (fmtQ[spibr_pkg::FMT_CKMORE] && tailQ > tailBase) begin
                        sclkQ <= ~sclkQ; // see R12
                    end
                    if (tailQ == 3'h1) begin
                        csnQ <= 1'b1; // see R24
                        stateQ <= spibr_pkg::ST_IDLE; // see R8
                    end
                end else if (!halfQ) begin
                    halfQ <= 1'b1;
                    sclkQ <= ~cpol;
                    if (!cpha) begin
                        rxQ <= {rxQ[6:0], sdiS}; // see R24
                    end else begin
                        sdoQ <= shQ[7]; // see R9
                        shQ <= {shQ[6:0], 1'b0};
                    end
                end else begin
                    halfQ <= 1'b0;
                    sclkQ <= cpol;
                    bitQ <= bitQ + 3'h1;
                    if (cpha) begin
                        rxQ <= {rxQ[6:0], sdiS}; // see R24
                    end
                    if (bitQ != 3'h7) begin
                        if (!cpha) begin
                            sdoQ <= shQ[6]; // see R9
                            shQ <= {shQ[6:0], 1'b0};
                        end
                    end else begin
                        if (stateQ == spibr_pkg::ST_CMD) begin
                            cmdIdxQ <= cmdIdxQ + 3'h1;
                        end else begin
                            cntQ <= cntQ + 9'h001; // see R23
                            txIdxQ <= txIdxQ + 8'h01;
                            rxIdxQ <= rxIdxQ + 8'h01;
                        end
                        if (more) begin
                            stateQ <= nextState;
                            shQ <= nextByte;
                            if (!cpha) begin
                                sdoQ <= nextByte[7];
                            end
                        end else begin
                            tailQ <= tailBase + (fmtQ[spibr_pkg::FMT_CKMORE]
                                ? spibr_pkg::TAIL_CLOCKS : 3'h0); // see R5
                        end
                    end
                end
            end
        end
    end

    // pins driven straight from flops
    assign spiClk = sclkQ; // see R21
    assign spiCsN = csnQ;
    assign spiDout = sdoQ;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ctrl_write;
        wrAcc && adr_i[15:2] == spibr_pkg::IDX_CTRL
            && enQ[spibr_pkg::EN_BIT] && stateQ == spibr_pkg::ST_IDLE && !goQ;
    endsequence
    property p_start;
        s_ctrl_write |=> goQ ##1 (stateQ != spibr_pkg::ST_IDLE
            || (!$past(ctrlQ[spibr_pkg::CTRL_DATAEN]) && cmdLen == 3'h0));
    endproperty
    a_start: assert property (p_start) else $error("start missed"); // see R2
    property p_idle_at_reset;
        $fell(rst) |-> stateQ == spibr_pkg::ST_IDLE && csnQ;
    endproperty
    a_idle_at_reset: assert property (p_idle_at_reset)
        else $error("not idle after reset"); // see R1
    property p_bypass;
        goQ && ce && ctrlQ[spibr_pkg::CTRL_BYPASS]
            |=> stateQ == spibr_pkg::ST_DATA && !csnQ;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass failed"); // see R3
    property p_cmd;
        goQ && ce && !ctrlQ[spibr_pkg::CTRL_BYPASS] && cmdLen != 3'h0
            |=> stateQ == spibr_pkg::ST_CMD;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command state missed"); // see R4
    property p_cmd_to_data;
        byteEnd && stateQ == spibr_pkg::ST_CMD && cmdLast
            && ctrlQ[spibr_pkg::CTRL_DATAEN] |=> stateQ == spibr_pkg::ST_DATA;
    endproperty
    a_cmd_to_data: assert property (p_cmd_to_data)
        else $error("no data phase"); // see R5
    property p_count;
        byteEnd && stateQ == spibr_pkg::ST_DATA |=> cntQ == $past(cntQ) + 9'h001;
    endproperty
    a_count: assert property (p_count) else $error("count wrong"); // see R23
    property p_finish;
        byteEnd && stateQ == spibr_pkg::ST_DATA && dataLast
            |=> finQ && tailQ != 3'h0;
    endproperty
    a_finish: assert property (p_finish) else $error("finish lost"); // see R18
    property p_port_inc;
        busWe |=> wrPtrQ == $past(wrPtrQ) + 8'h01;
    endproperty
    a_port_inc: assert property (p_port_inc)
        else $error("pointer not bumped"); // see R15
    property p_cs_low;
        stateQ != spibr_pkg::ST_IDLE && tailQ == 3'h0 |-> !csnQ;
    endproperty
    a_cs_low: assert property (p_cs_low) else $error("select high"); // see R24
endmodule
`default_nettype wire

// ===== testbench/spibr_slave.sv
// behavioural spi slave: logs bytes seen, answers 8'h5a plus byte index
`timescale 1ns/1ps
`default_nettype none
module spibr_slave (
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiDout,
    output logic spiDin
);
    logic [7:0] rxLog [0:15];
    logic [7:0] sh;
    int nBits = 0;
    initial spiDin = 1'b0;
    function automatic logic ans(input int n);
        logic [7:0] b;
        b = 8'h5a + 8'(n / 8);
        return b[7 - n % 8];
    endfunction
    always @(negedge spiCsN) begin
        nBits = 0;
        spiDin = ans(0);
    end
    // released line shows the inverse of the last bit
    always @(posedge spiCsN) spiDin = ~spiDin;
    always @(posedge spiClk) if (!spiCsN) begin
        sh = {sh[6:0], spiDout};
        nBits = nBits + 1;
        if (nBits % 8 == 0) rxLog[(nBits / 8 - 1) % 16] = sh;
    end
    always @(negedge spiClk) if (!spiCsN) spiDin = ans(nBits);
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the buffered spi master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, cyc, stb, we, ack, sck, csN, mosi, miso;
    logic [15:0] adr;
    logic [7:0] wdat, rdat, q;
    logic [7:0] txb [0:2] = '{8'h81, 8'h02, 8'h40};
    int n_errors = 0;
    int n_checks = 0;
    int i;
    spibr_top dut (.clk(clk), .rst(rst), .ce(1'b1), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(1'b1),
        .dat_o(rdat), .ack_o(ack), .spiClk(sck), .spiCsN(csN),
        .spiDout(mosi), .spiDin(miso));
    spibr_slave slave (.spiClk(sck), .spiCsN(csN), .spiDout(mosi),
        .spiDin(miso));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [13:0] idx, input logic w,
            input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        k = 0;
        // ack and read data are taken as sampled at the rising edge
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 100);
        if (ack !== 1'b1) begin
            n_errors++;
            results();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        check(q, exp);
    endtask
    task automatic frame(input logic [7:0] ctrl);
        int k;
        bus(spibr_pkg::IDX_CTRL, 1'b1, ctrl);
        for (k = 0; k < 9000 && csN !== 1'b0; k++) @(negedge clk);
        for (; k < 9000 && csN !== 1'b1; k++) @(negedge clk);
        if (k == 9000) begin
            n_errors++;
            results();
        end
    endtask
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0000;
        wdat = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(spibr_pkg::IDX_COUNT, 8'h00);
        bus(spibr_pkg::IDX_COUNT, 1'b1, 8'hff);
        rd(spibr_pkg::IDX_COUNT, 8'h00);
        rd(14'h0000, 8'h00);
        rd(spibr_pkg::IDX_WPTR, 8'h00);
        $display("test reset done");
        for (i = 0; i < 3; i++) bus(spibr_pkg::IDX_PORT, 1'b1, txb[i]);
        rd(spibr_pkg::IDX_WPTR, 8'h03);
        bus(spibr_pkg::IDX_RPTR, 1'b1, 8'h01);
        rd(spibr_pkg::IDX_PORT, 8'h02);
        rd(spibr_pkg::IDX_RPTR, 8'h02);
        $display("test buffer done");
        // divider 3 gives a 200 ns serial clock
        bus(spibr_pkg::IDX_ENABLE, 1'b1, 8'h83);
        rd(spibr_pkg::IDX_ENABLE, 8'h83);
        bus(spibr_pkg::IDX_CMD0, 1'b1, 8'h9c);
        bus(spibr_pkg::IDX_CMD0 + 14'h0001, 1'b1, 8'h0e);
        bus(spibr_pkg::IDX_DLEN, 1'b1, 8'h03);
        frame(8'h12);
        check(slave.rxLog[0], 8'h9c);
        check(slave.rxLog[1], 8'h0e);
        for (i = 0; i < 3; i++) check(slave.rxLog[i + 2], txb[i]);
        check(8'(slave.nBits), 8'h28);
        rd(spibr_pkg::IDX_COUNT, 8'h03);
        rd(spibr_pkg::IDX_STATUS, 8'h01);
        bus(spibr_pkg::IDX_STATUS, 1'b1, 8'h00);
        rd(spibr_pkg::IDX_STATUS, 8'h01);
        bus(spibr_pkg::IDX_STATUS, 1'b1, 8'h01);
        rd(spibr_pkg::IDX_STATUS, 8'h00);
        $display("test command and write done");
        frame(8'h01);
        check(8'(slave.nBits), 8'h08);
        rd(spibr_pkg::IDX_COUNT, 8'h00);
        $display("test command only done");
        bus(spibr_pkg::IDX_ENABLE, 1'b1, 8'hc3);
        bus(spibr_pkg::IDX_DLEN, 1'b1, 8'h02);
        frame(8'h38);
        check(8'(slave.nBits), 8'h10);
        check(slave.rxLog[1], 8'h02);
        bus(spibr_pkg::IDX_RPTR, 1'b1, 8'h80);
        rd(spibr_pkg::IDX_PORT, 8'h5a);
        rd(spibr_pkg::IDX_PORT, 8'h5b);
        $display("test bidirectional done");
        bus(spibr_pkg::IDX_ENABLE, 1'b1, 8'h83);
        bus(spibr_pkg::IDX_DLEN, 1'b1, 8'h10);
        bus(spibr_pkg::IDX_MID, 1'b1, 8'h10);
        frame(8'h38);
        for (i = 0; i < 16; i++) check(slave.rxLog[i], 8'hff);
        bus(spibr_pkg::IDX_RPTR, 1'b1, 8'h00);
        for (i = 0; i < 16; i++) rd(spibr_pkg::IDX_PORT, 8'h5a + 8'(i));
        rd(spibr_pkg::IDX_COUNT, 8'h10);
        rd(spibr_pkg::IDX_STATUS, 8'h03);
        $display("test read done");
        // polarity 1, phase 1, all extra timing and one extra clock pulse
        bus(spibr_pkg::IDX_FMT, 1'b1, 8'h1f);
        bus(spibr_pkg::IDX_DLEN, 1'b1, 8'h01);
        frame(8'h19);
        check({7'h00, sck}, 8'h01);
        check(slave.rxLog[0], 8'h9c);
        check(slave.rxLog[1], 8'hff);
        check(8'(slave.nBits), 8'h11);
        rd(spibr_pkg::IDX_COUNT, 8'h01);
        bus(spibr_pkg::IDX_RPTR, 1'b1, 8'h00);
        rd(spibr_pkg::IDX_PORT, 8'h5b);
        $display("test format done");
        results();
    end
endmodule
`default_nettype wire
